// ---- rtl/dsm_defines.svh ----
// constants of the drive status monitor: offsets, reset values, timing
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define DSM_A_CTRL 8'h00
`define DSM_A_ZC_LVL 8'h04
`define DSM_A_ZC_DLY 8'h08
`define DSM_A_OL_LVL 8'h0C
`define DSM_A_OL_DLY 8'h10
`define DSM_A_WIN1 8'h14
`define DSM_A_WIN2 8'h18
`define DSM_A_TR_DUR 8'h1C
`define DSM_A_AI_LIM 8'h20
`define DSM_A_TEMP 8'h24
`define DSM_A_WAKE 8'h28
`define DSM_A_SLEEP 8'h2C
`define DSM_A_RUN_TGT 8'h30
`define DSM_A_OL_GAIN 8'h34
`define DSM_A_FLAGS 8'h38
`define DSM_A_TR_REM 8'h3C
`define DSM_A_IRQ_ST 8'h40
`define DSM_A_IRQ_CLR 8'h44
`define DSM_A_IRQ_EN 8'h48
// ****************************************
// control register bit positions
// ****************************************
`define DSM_B_TR_EN 0
`define DSM_B_FAN_MODE 1
`define DSM_B_OL_EN 2
// ****************************************
// reset values (0.1 %, 0.01 s, 0.01 V, deg C, 0.01 Hz, 0.1 s, 0.1 min)
// ****************************************
`define DSM_R_ZC_LVL 16'h0032
`define DSM_R_ZC_DLY 16'h000A
`define DSM_R_OL_LVL 16'h07D0
`define DSM_R_OL_DLY 16'h0000
`define DSM_R_WIN_TGT 16'h03E8
`define DSM_R_WIN_AMP 16'h0000
`define DSM_R_AI_LO 16'h0136
`define DSM_R_AI_HI 16'h02A8
`define DSM_R_TEMP 8'h5A
`define DSM_R_OL_GAIN 16'h0064
`define DSM_R_OL_EN 1'b1
// ****************************************
// timing
// ****************************************
`define DSM_CLK_NS 10
`define DSM_TICK_MS 10
`define DSM_TICK_CYC ((`DSM_TICK_MS * 1000000) / `DSM_CLK_NS)
`define DSM_TENTH_MIN_MS 6000
`define DSM_TENTH_TICKS (`DSM_TENTH_MIN_MS / `DSM_TICK_MS)
`define DSM_OL_MIN_S 120
`define DSM_OL_MIN_TICKS ((`DSM_OL_MIN_S * 1000) / `DSM_TICK_MS)
`define DSM_FAN_TEMP 40
`define DSM_TR_MAX 65000
`endif

// ---- rtl/dsm_pkg.sv ----
// types of the drive status monitor
package dsm_pkg;
   // ****************************************
   // measurement inputs from the control core
   // ****************************************
   typedef struct packed {
      logic [15:0] cur;      // output current, 0.1 % of rated
      logic [15:0] ai1;      // analog input 1, 0.01 V
      logic [7:0] temp;      // heat-sink, deg C
      logic [15:0] set_freq; // set frequency, 0.01 Hz
   } dsm_meas_t;
   // ****************************************
   // digital output flags
   // ****************************************
   typedef struct packed {
      logic sleeping;
      logic overload;
      logic run_time_hit;
      logic temp_hit;
      logic ai1_out;
      logic timed_done;
      logic win2;
      logic win1;
      logic over_lim;
      logic zero_cur;
   } dsm_flags_t;
   // ****************************************
   // sleep / wake control states
   // ****************************************
   typedef enum logic [0:0] {
      DSM_AWAKE,
      DSM_ASLEEP
   } dsm_sleep_t;
endpackage : dsm_pkg

// ---- rtl/dsm_monitor.sv ----
// drive status monitor: thresholds, timers, fan, sleep, overload, wishbone
//
// Notes on behaviour
// - zero-current flag after level held past delay
// - over-limit flag after delay; level zero disables
// - two current windows, target plus/minus amplitude
// - timed run stops drive and flags together
// - timed counter cleared at start; remaining readable
// - timed duration in tenth minutes; elapsed count capped at 65000
// - analog input 1 outside limits raises flag
// - heat-sink reaching threshold raises temperature flag
// - fan mode zero: running, or stopped above 40
// - fan mode one: fan always on
// - low set frequency for sleep delay sleeps
// - asleep, run command, high frequency wakes after delay
// - both frequencies zero disables sleep and wake
// - this-run time flag once elapsed reaches target
// - overload judged from current against time
// - overload never before two minutes; gain scales
`include "dsm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dsm_monitor #(
   parameter int TICK_CYCLES = `DSM_TICK_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // control core
   input wire dsm_pkg::dsm_meas_t meas,
   input wire logic running,
   input wire logic run_cmd,
   input wire logic start,
   // outputs to terminals and run logic
   output dsm_pkg::dsm_flags_t flags,
   output logic stop_req,
   output logic fan_on,
   output logic irq
);
   import dsm_pkg::*;

   if (TICK_CYCLES < 2) begin : g_tick_chk
      $error("tick period too short");
   end

   // ****************************************
   // configuration registers
   // ****************************************
   logic tr_en_r;          // timed run enable
   logic fan_mode_r;       // 0: by run state and heat, 1: always
   logic ol_en_r;          // overload protection enable
   logic [15:0] zc_lvl_r;  // zero-current level
   logic [15:0] zc_dly_r;  // zero-current delay, 0.01 s
   logic [15:0] ol_lvl_r;  // over-limit level, 0 disables
   logic [15:0] ol_dly_r;  // over-limit delay, 0.01 s
   logic [31:0] win1_r;    // [31:16] amplitude, [15:0] target
   logic [31:0] win2_r;
   logic [15:0] tr_dur_r;  // timed run duration, 0.1 min
   logic [31:0] ai_lim_r;  // [31:16] upper, [15:0] lower
   logic [7:0] temp_r;     // heat-sink temperature threshold
   logic [31:0] wake_r;    // [31:16] delay 0.1 s, [15:0] frequency
   logic [31:0] sleep_r;   // same layout as wake
   logic [15:0] run_tgt_r; // this-run target, 0.1 min
   logic [15:0] ol_gain_r; // overload gain, 0.01 units
   logic [9:0] irq_st_r;   // sticky events
   logic [9:0] irq_en_r;   // event enables

   // ****************************************
   // bus decode
   // ****************************************
   logic req;       // new access this cycle
   logic wr;        // new write this cycle
   logic [31:0] bm; // byte-lane mask
   logic [9:0] clr; // write-one-to-clear pattern
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign clr = (wr && wb_adr_i == `DSM_A_IRQ_CLR) ? (wb_dat_i[9:0] & bm[9:0]) : 10'h000;

   // merge written lanes into the old word
   function automatic logic [31:0] mrg(input logic [31:0] old);
      mrg = (old & ~bm) | (wb_dat_i & bm);
   endfunction : mrg

   // config writes; only selected lanes change
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tr_en_r <= 1'b0;
         fan_mode_r <= 1'b0;
         ol_en_r <= `DSM_R_OL_EN;
         zc_lvl_r <= `DSM_R_ZC_LVL;
         zc_dly_r <= `DSM_R_ZC_DLY;
         ol_lvl_r <= `DSM_R_OL_LVL;
         ol_dly_r <= `DSM_R_OL_DLY;
         win1_r <= {`DSM_R_WIN_AMP, `DSM_R_WIN_TGT};
         win2_r <= {`DSM_R_WIN_AMP, `DSM_R_WIN_TGT};
         tr_dur_r <= 16'h0000;
         ai_lim_r <= {`DSM_R_AI_HI, `DSM_R_AI_LO};
         temp_r <= `DSM_R_TEMP;
         wake_r <= 32'h0000_0000;
         sleep_r <= 32'h0000_0000;
         run_tgt_r <= 16'h0000;
         ol_gain_r <= `DSM_R_OL_GAIN;
         irq_en_r <= 10'h000;
      end else if (wr) begin
         case (wb_adr_i)
            `DSM_A_CTRL: begin
               {ol_en_r, fan_mode_r, tr_en_r} <= 3'(mrg({29'h0, ol_en_r, fan_mode_r, tr_en_r}));
            end
            `DSM_A_ZC_LVL: zc_lvl_r <= 16'(mrg({16'h0, zc_lvl_r}));
            `DSM_A_ZC_DLY: zc_dly_r <= 16'(mrg({16'h0, zc_dly_r}));
            `DSM_A_OL_LVL: ol_lvl_r <= 16'(mrg({16'h0, ol_lvl_r}));
            `DSM_A_OL_DLY: ol_dly_r <= 16'(mrg({16'h0, ol_dly_r}));
            `DSM_A_WIN1: win1_r <= mrg(win1_r);
            `DSM_A_WIN2: win2_r <= mrg(win2_r);
            `DSM_A_TR_DUR: tr_dur_r <= 16'(mrg({16'h0, tr_dur_r}));
            `DSM_A_AI_LIM: ai_lim_r <= mrg(ai_lim_r);
            `DSM_A_TEMP: temp_r <= 8'(mrg({24'h0, temp_r}));
            `DSM_A_WAKE: wake_r <= mrg(wake_r);
            `DSM_A_SLEEP: sleep_r <= mrg(sleep_r);
            `DSM_A_RUN_TGT: run_tgt_r <= 16'(mrg({16'h0, run_tgt_r}));
            `DSM_A_OL_GAIN: ol_gain_r <= 16'(mrg({16'h0, ol_gain_r}));
            `DSM_A_IRQ_EN: irq_en_r <= 10'(mrg({22'h0, irq_en_r}));
            default: ; // read-only, unmapped or irq clear: no setting changes here
         endcase
      end
   end

   // ****************************************
   // time base: one pulse per 10 ms
   // ****************************************
   logic [31:0] pre_r; // prescaler
   logic tick_r;       // one-cycle tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else if (pre_r == 32'(TICK_CYCLES - 1)) begin
         pre_r <= 32'h0000_0000;
         tick_r <= 1'b1;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
         tick_r <= 1'b0;
      end
   end

   // ****************************************
   // plain comparators
   // ****************************************
   logic [1:0] win_in; // current inside each window
   logic ai_out;       // analog input 1 outside limits
   logic temp_hit;     // heat sink at threshold
   logic hot;          // above fan threshold
   logic slp_en;       // sleep function enabled
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_win
         logic [31:0] w;
         assign w = (g == 0) ? win1_r : win2_r;
         // 17-bit sums so target plus amplitude cannot wrap
         assign win_in[g] = ({1'b0, meas.cur} + {1'b0, w[31:16]} >= {1'b0, w[15:0]}) &&
            ({1'b0, meas.cur} <= {1'b0, w[15:0]} + {1'b0, w[31:16]});
      end
   endgenerate
   assign ai_out = meas.ai1 > ai_lim_r[31:16] || meas.ai1 < ai_lim_r[15:0];
   assign temp_hit = meas.temp >= temp_r;
   assign hot = meas.temp > 8'(`DSM_FAN_TEMP);
   assign slp_en = !(wake_r[15:0] == 16'h0000 && sleep_r[15:0] == 16'h0000);

   // ****************************************
   // delayed detectors: zero, over-limit, sleep, wake
   // ****************************************
   dsm_sleep_t st_r;   // sleep state
   logic [3:0] cond;   // condition of each timer
   logic [19:0] lim [4]; // delay of each timer in ticks
   logic [3:0] done;   // held longer than delay
   assign cond[0] = meas.cur <= zc_lvl_r;
   assign cond[1] = ol_lvl_r != 16'h0000 && meas.cur > ol_lvl_r;
   assign cond[2] = slp_en && st_r == DSM_AWAKE && running &&
      meas.set_freq <= sleep_r[15:0];
   assign cond[3] = slp_en && st_r == DSM_ASLEEP && run_cmd &&
      meas.set_freq >= wake_r[15:0];
   // 0.1 s delays are ten ticks each
   assign lim[0] = {4'h0, zc_dly_r};
   assign lim[1] = {4'h0, ol_dly_r};
   assign lim[2] = 20'(sleep_r[31:16] * 20'd10);
   assign lim[3] = 20'(wake_r[31:16] * 20'd10);
   generate
      for (g = 0; g < 4; g++) begin : g_tmr
         logic [19:0] cnt_r; // ticks the condition has held
         // a dropped condition restarts the wait from zero
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               cnt_r <= 20'h00000;
            end else if (!cond[g]) begin
               cnt_r <= 20'h00000;
            end else if (tick_r && cnt_r != 20'hFFFFF) begin
               cnt_r <= cnt_r + 20'h00001;
            end
         end
         assign done[g] = cond[g] && cnt_r > lim[g];
      end
   endgenerate

   // sleep state machine; clearing both frequencies wakes at once
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= DSM_AWAKE;
      end else if (!slp_en) begin
         st_r <= DSM_AWAKE;
      end else begin
         case (st_r)
            DSM_AWAKE: if (done[2]) st_r <= DSM_ASLEEP;
            DSM_ASLEEP: if (done[3]) st_r <= DSM_AWAKE;
            default: st_r <= DSM_AWAKE;
         endcase
      end
   end

   // ****************************************
   // run timing in tenths of a minute
   // ****************************************
   logic [15:0] sub_r; // ticks within the tenth
   logic [15:0] el_r;  // elapsed tenths this run
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sub_r <= 16'h0000;
         el_r <= 16'h0000;
      end else if (start) begin
         sub_r <= 16'h0000;
         el_r <= 16'h0000;
      end else if (running && tick_r) begin
         if (sub_r == 16'(`DSM_TENTH_TICKS - 1)) begin
            sub_r <= 16'h0000;
            if (el_r != 16'(`DSM_TR_MAX)) el_r <= el_r + 16'h0001;
         end else begin
            sub_r <= sub_r + 16'h0001;
         end
      end
   end

   // timed run latches its stop until the next start or until timed run is disabled
   logic tr_stop_r; // timed run has expired
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tr_stop_r <= 1'b0;
      end else if (start || !tr_en_r) begin
         tr_stop_r <= 1'b0;
      end else if (running && el_r >= tr_dur_r) begin
         tr_stop_r <= 1'b1;
      end
   end

   // ****************************************
   // overload: time above gain-scaled rated current
   // ****************************************
   // the curve is a flat two-minute hold above the scaled level; it
   // never fires early, but it does not speed up at high current
   logic ol_cond;     // current above gain times rated
   logic [19:0] ol_r; // ticks above level
   assign ol_cond = ol_en_r && {4'h0, meas.cur} > 20'(ol_gain_r * 20'd10);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ol_r <= 20'h00000;
      end else if (!ol_cond) begin
         ol_r <= 20'h00000;
      end else if (tick_r && ol_r != 20'hFFFFF) begin
         ol_r <= ol_r + 20'h00001;
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   dsm_flags_t fl; // next flag value
   always_comb begin
      fl.zero_cur = done[0];
      fl.over_lim = done[1];
      fl.win1 = win_in[0];
      fl.win2 = win_in[1];
      fl.timed_done = tr_stop_r;
      fl.ai1_out = ai_out;
      fl.temp_hit = temp_hit;
      fl.run_time_hit = running && run_tgt_r != 16'h0000 && el_r >= run_tgt_r;
      fl.overload = ol_cond && ol_r >= 20'(`DSM_OL_MIN_TICKS);
      fl.sleeping = st_r == DSM_ASLEEP;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
         stop_req <= 1'b0;
      end else begin
         flags <= fl;
         stop_req <= tr_stop_r || st_r == DSM_ASLEEP;
      end
   end

   // fan follows mode; mode one ignores run state and heat
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fan_on <= 1'b0;
      end else if (fan_mode_r) begin
         fan_on <= 1'b1;
      end else begin
         fan_on <= running || hot;
      end
   end

   // ****************************************
   // interrupts: rising flag edges, set beats clear
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_st_r <= 10'h000;
         irq <= 1'b0;
      end else begin
         irq_st_r <= (irq_st_r & ~clr) | (fl & ~flags);
         irq <= |(irq_st_r & irq_en_r);
      end
   end

   // ****************************************
   // wishbone answer: ack one cycle after request
   // ****************************************
   logic [15:0] rem; // remaining timed run
   assign rem = (el_r >= tr_dur_r) ? 16'h0000 : tr_dur_r - el_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0000_0000;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               `DSM_A_CTRL: wb_dat_o <= {29'h0, ol_en_r, fan_mode_r, tr_en_r};
               `DSM_A_ZC_LVL: wb_dat_o <= {16'h0, zc_lvl_r};
               `DSM_A_ZC_DLY: wb_dat_o <= {16'h0, zc_dly_r};
               `DSM_A_OL_LVL: wb_dat_o <= {16'h0, ol_lvl_r};
               `DSM_A_OL_DLY: wb_dat_o <= {16'h0, ol_dly_r};
               `DSM_A_WIN1: wb_dat_o <= win1_r;
               `DSM_A_WIN2: wb_dat_o <= win2_r;
               `DSM_A_TR_DUR: wb_dat_o <= {16'h0, tr_dur_r};
               `DSM_A_AI_LIM: wb_dat_o <= ai_lim_r;
               `DSM_A_TEMP: wb_dat_o <= {24'h0, temp_r};
               `DSM_A_WAKE: wb_dat_o <= wake_r;
               `DSM_A_SLEEP: wb_dat_o <= sleep_r;
               `DSM_A_RUN_TGT: wb_dat_o <= {16'h0, run_tgt_r};
               `DSM_A_OL_GAIN: wb_dat_o <= {16'h0, ol_gain_r};
               `DSM_A_FLAGS: wb_dat_o <= {22'h0, flags};
               `DSM_A_TR_REM: wb_dat_o <= {16'h0, rem};
               `DSM_A_IRQ_ST: wb_dat_o <= {22'h0, irq_st_r};
               `DSM_A_IRQ_EN: wb_dat_o <= {22'h0, irq_en_r};
               default: wb_dat_o <= 32'h0000_0000; // unmapped reads 0
            endcase
         end
      end
   end
endmodule : dsm_monitor
`default_nettype wire

// ---- tb/dsm_chk_monitor.sv ----
// assertion checker bound to the drive status monitor ports
`include "dsm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dsm_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // wishbone side
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // control core side
   input wire dsm_pkg::dsm_meas_t meas,
   input wire logic running,
   input wire logic run_cmd,
   input wire logic start,
   // outputs
   input wire dsm_pkg::dsm_flags_t flags,
   input wire logic stop_req,
   input wire logic fan_on,
   input wire logic irq
);
   import dsm_pkg::*;
   // ****************************************
   // shadow of the thresholds written by software
   // ****************************************
   logic [2:0] ctrl_r; // control bits
   logic [15:0] zc_r, ol_r, lo_r, hi_r, t1_r, a1_r; // levels, window one
   logic [7:0] temp_r; // temperature threshold
   logic wr, ai_bad, w1_in, fan_exp;
   // write lands at the edge it is taken
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign ai_bad = (meas.ai1 > hi_r) || (meas.ai1 < lo_r);
   // 17-bit sums: window edges may pass 16 bits
   assign w1_in = ({1'b0, meas.cur} + a1_r >= {1'b0, t1_r}) && ({1'b0, meas.cur} <= t1_r + a1_r);
   assign fan_exp = ctrl_r[`DSM_B_FAN_MODE] || running || (meas.temp > 8'(`DSM_FAN_TEMP));
   // sel is not modelled: the bench always writes whole words
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= 3'h4;
         zc_r <= `DSM_R_ZC_LVL;
         ol_r <= `DSM_R_OL_LVL;
         lo_r <= `DSM_R_AI_LO;
         hi_r <= `DSM_R_AI_HI;
         t1_r <= `DSM_R_WIN_TGT;
         a1_r <= `DSM_R_WIN_AMP;
         temp_r <= `DSM_R_TEMP;
      end else if (wr) begin
         case (wb_adr_i)
            `DSM_A_CTRL: ctrl_r <= wb_dat_i[2:0];
            `DSM_A_ZC_LVL: zc_r <= wb_dat_i[15:0];
            `DSM_A_OL_LVL: ol_r <= wb_dat_i[15:0];
            `DSM_A_WIN1: {a1_r, t1_r} <= wb_dat_i;
            `DSM_A_AI_LIM: {hi_r, lo_r} <= wb_dat_i;
            `DSM_A_TEMP: temp_r <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ****************************************
   // properties
   // ****************************************
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered on the next edge");
   a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_fan_control: assert property (1'b1 |=> fan_on == $past(fan_exp))
      else $error("fan output wrong for mode, run state and temperature");
   a_ai_range: assert property (1'b1 |=> flags.ai1_out == $past(ai_bad))
      else $error("analog input range flag wrong");
   a_temp_reach: assert property (1'b1 |=> flags.temp_hit == $past(meas.temp >= temp_r))
      else $error("temperature flag wrong");
   a_zc_drop: assert property (meas.cur > zc_r |=> !flags.zero_cur)
      else $error("zero current flag kept above level");
   a_win1_match: assert property (1'b1 |=> flags.win1 == $past(w1_in))
      else $error("window one flag wrong");
   a_stop_cause: assert property (stop_req == (flags.timed_done || flags.sleeping))
      else $error("stop request not matching timed stop or sleep");
   a_ol_off: assert property (ol_r == 16'h0000 |=> !flags.over_lim)
      else $error("over limit flag with detection off");
endmodule : dsm_chk
bind dsm_monitor dsm_chk chk_u (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .meas, .running, .run_cmd, .start, .flags,
   .stop_req, .fan_on, .irq);
`default_nettype wire

// ---- tb/dsm_core_model.sv ----
// behavioural model of the inverter run logic around the monitor
`timescale 1ns/100ps
`default_nettype none
module dsm_core_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // operator command and stop from the block
   input wire logic cmd,
   input wire logic stop_req,
   // run state toward the block
   output logic running,
   output logic run_cmd,
   output logic start
);
   logic cmd_d_r; // last command, for the start edge
   // set frequency is driven by the bench; no pid loop is modelled
   assign run_cmd = cmd;
   // start pulse per new command; the drive obeys every stop request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_d_r <= 1'b0;
         start <= 1'b0;
         running <= 1'b0;
      end else begin
         cmd_d_r <= cmd;
         start <= cmd && !cmd_d_r;
         running <= cmd && !stop_req;
      end
   end
endmodule : dsm_core_model
`default_nettype wire

// ---- tb/dsm_monitor_tb.sv ----
// self-checking bench for the drive status monitor
`timescale 1ns/100ps
`default_nettype none
module dsm_monitor_tb;
   import dsm_pkg::*;
   localparam int TICK = 4; // short tick for a short run
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cmd = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rd_o;
   logic ack, running, run_cmd, start, stop_req, fan_on, irq;
   dsm_meas_t meas = '{16'h01F4, 16'h0190, 8'h1E, 16'h1388}; // quiet operating point
   dsm_flags_t flags;
   logic [12:0] obs; // outputs by index
   logic [31:0] exp_q [$]; // expected reads
   int err_count = 0, n_checks = 0;
   logic [15:0] tg, am;
   logic [39:0] rv [9] = '{40'h00_00000004, 40'h04_00000032, 40'h08_0000000A,
      40'h0C_000007D0, 40'h14_000003E8, 40'h20_02A80136, 40'h24_0000005A,
      40'h34_00000064, 40'h4C_00000000}; // address and reset value
   assign obs = {irq, fan_on, stop_req, flags};
   always #5 ref_clk = ~ref_clk;
   dsm_monitor #(.TICK_CYCLES(TICK)) dut_u (.ref_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd_o),
      .wb_ack_o(ack), .meas, .running, .run_cmd, .start, .flags, .stop_req, .fan_on, .irq);
   dsm_core_model core_u (.ref_clk, .rst, .cmd, .stop_req, .running, .run_cmd, .start);
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (err_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // hold the request until ack is sampled, then one idle edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge ref_clk);
      while (ack !== 1'b1 && n < 20) begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 20) check("bus_wait", 32'(n), 32'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd
   // bounded wait for an output level, latency checked
   task automatic wait_obs(input int i, input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (obs[i] !== v && n <= hi) begin
         @(posedge ref_clk);
         n++;
      end
      if (n > hi) check("wait_bound", 32'(n), 32'(hi));
      check("latency_low", 32'(n >= lo), 32'h1);
   endtask : wait_obs
   // compare each read ack with the oldest note
   always @(posedge ref_clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check("read_data", rd_o, exp_q.pop_front());
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h6B90));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 9; i++) rd(rv[i][39:32], rv[i][31:0]);
      wr(8'h38, 32'h3FF); // read-only place ignores the write
      rd(8'h38, 32'h0);
      wr(8'h00, 32'h6);
      check("fan_mode1", 32'(fan_on), 32'h1);
      wr(8'h00, 32'h4);
      check("fan_mode0", 32'(fan_on), 32'h0);
      // random windows, analog input and temperature
      tg = 16'h012C + 16'($urandom % 1700);
      am = 16'($urandom % 300);
      wr(8'h18, {am, tg});
      wr(8'h14, {am, tg + 16'h0032});
      for (int i = 0; i < 8; i++) begin
         meas.cur <= tg - 16'h012C + 16'($urandom % 600);
         meas.ai1 <= 16'($urandom % 1000);
         meas.temp <= 8'($urandom % 100);
         repeat (2) @(posedge ref_clk);
         check("win2", 32'(flags.win2), 32'((meas.cur + am >= tg) && (meas.cur <= tg + am)));
         check("ai1_out", 32'(flags.ai1_out), 32'(meas.ai1 > 16'h02A8 || meas.ai1 < 16'h0136));
         check("temp_hit", 32'(flags.temp_hit), 32'(meas.temp >= 8'h5A));
         check("fan_stopped", 32'(fan_on), 32'(meas.temp > 8'h28));
      end
      // interrupt: raised while masked, enabled, cleared
      meas <= '{16'h01F4, 16'h0190, 8'h1E, 16'h1388};
      repeat (4) @(posedge ref_clk);
      wr(8'h44, 32'h3FF);
      rd(8'h40, 32'h0);
      meas.cur <= 16'h0000;
      wait_obs(0, 1'b1, 40, 52);
      check("irq_masked", 32'(irq), 32'h0);
      rd(8'h40, 32'h1);
      wr(8'h48, 32'h1);
      wait_obs(12, 1'b1, 0, 3);
      wr(8'h44, 32'h1);
      wait_obs(12, 1'b0, 0, 3);
      meas.cur <= 16'h01F4;
      wait_obs(0, 1'b0, 0, 3);
      // over-limit with zero delay, then detection switched off
      meas.cur <= 16'h07D1;
      wait_obs(1, 1'b1, 0, 12);
      wr(8'h0C, 32'h0);
      repeat (12) @(posedge ref_clk);
      check("ol_off", 32'(flags.over_lim), 32'h0);
      meas.cur <= 16'h01F4;
      // timed run of one tenth minute, run-time target alike
      wr(8'h1C, 32'h1);
      wr(8'h30, 32'h1);
      wr(8'h00, 32'h5);
      cmd <= 1'b1;
      wait_obs(4, 1'b1, 2390, 2420);
      check("timed_stop", 32'(stop_req), 32'h1);
      wait_obs(7, 1'b1, 0, 2);
      cmd <= 1'b0;
      @(posedge ref_clk);
      cmd <= 1'b1;
      wait_obs(4, 1'b0, 0, 4);
      rd(8'h3C, 32'h1);
      wr(8'h00, 32'h4);
      // sleep below one frequency, wake above the other
      wr(8'h2C, 32'h0001_03E8);
      wr(8'h28, 32'h0001_07D0);
      meas.set_freq <= 16'h01F4;
      wait_obs(9, 1'b1, 40, 52);
      meas.set_freq <= 16'h09C4;
      wait_obs(9, 1'b0, 40, 52);
      wr(8'h28, 32'h0);
      wr(8'h2C, 32'h0);
      meas.set_freq <= 16'h0000;
      repeat (60) @(posedge ref_clk);
      check("sleep_off", 32'(flags.sleeping), 32'h0);
      meas.cur <= 16'h07D1;
      wait_obs(8, 1'b1, 47990, 48010);
      print_verdict();
   end
endmodule : dsm_monitor_tb
`default_nettype wire
